// ---- hdl/dms_defines.svh ----
// Constants for the DDR2 command decoder and mode-register store.
// Assumes inclusion by dms_top and dms_row_table only; definitions only.
// How it works
// - Reads and writes run as bursts of four or eight beats, programmed order.
// - Activate opens a bank; bank bits pick bank, address bits pick row.
// - Read/write address gives start column; bit ten requests auto precharge.
// - Mode writes and loop resets leave stored contents untouched.
// - Mode register is undefined after power-up; it must be written first.
// - Mode fields: length, type, latency, test, loop reset, write recovery.
// - Extended register one: loop, drive, latency, calibration, strobes, termination.
// - Precharge samples address bit ten: low one bank, high all banks.
// - With read strobe enabled on an x8 part the write mask is off; strobe driven on reads.
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH

`define DMS_ADDR_W 14
`define DMS_BANK_W 3
`define DMS_BANKS 8
`define DMS_COL_W 10
`define DMS_AP_BIT 10
`define DMS_ALLBANK_BIT 10

// Target register selected by the bank bits of a mode-set
`define DMS_SEL_MODE 3'h0
`define DMS_SEL_EXT1 3'h1
`define DMS_SEL_EXT2 3'h2
`define DMS_SEL_EXT3 3'h3

// Mode register fields
`define DMS_MR_BL_LSB 0
`define DMS_MR_BL_MSB 2
`define DMS_MR_BT_BIT 3
`define DMS_MR_DLLRST_BIT 8
`define DMS_BL_CODE_4 3'h2
`define DMS_BL_CODE_8 3'h3

// Extended register one fields
`define DMS_E1_DLLDIS_BIT 0
`define DMS_E1_HALFDRV_BIT 1
`define DMS_E1_RTT0_BIT 2
`define DMS_E1_RTT1_BIT 6
`define DMS_E1_DQSNDIS_BIT 10
`define DMS_E1_RSTROBE_BIT 11

`define DMS_WORD_RESET 14'h0000

// Loop settling after a reset, in link clocks
`define DMS_DLL_LOCK_CLKS 200

`endif

// ---- hdl/dms_pkg.sv ----
// Types shared by the DDR2 command decoder files.
// Assumes dms_defines.svh is compiled alongside for widths.
package dms_pkg;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] addr;
  } dms_cmd_s;

  typedef enum logic [2:0] {
    BST_IDLE = 3'h1,
    BST_READ = 3'h2,
    BST_WRITE = 3'h4
  } dms_burst_e;

  typedef struct packed {
    logic valid;
    logic [13:0] mode_word;
    logic [13:0] ext1_word;
  } dms_status_s;

endpackage : dms_pkg

// ---- hdl/dms_row_table.sv ----
// Open-row memory: one row address per bank, registered read data.
// Assumes a single clock; write and read may fall in the same cycle.
`timescale 1ns/100ps
`include "dms_defines.svh"

module dms_row_table #(
  parameter int ROW_W = 14,
  parameter int DEPTH = 8
) (
  input wire logic clk, // Link clock
  input wire logic wr_en, // Store a row
  input wire logic [$clog2(DEPTH)-1:0] wr_idx, // Bank written
  input wire logic [ROW_W-1:0] wr_row, // Row stored
  input wire logic [$clog2(DEPTH)-1:0] rd_idx, // Bank read
  output logic [ROW_W-1:0] rd_row // Row read, one cycle later
);

  logic [ROW_W-1:0] mem_r [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_idx] <= wr_row;
    end
  end

  // Write-through so a write and a read of the same bank in the same cycle agree
  always_ff @(posedge clk) begin
    if (wr_en && wr_idx == rd_idx) begin
      rd_row <= wr_row;
    end else begin
      rd_row <= mem_r[rd_idx];
    end
  end

endmodule : dms_row_table

// ---- hdl/dms_top.sv ----
// DDR2 command decoder: bank/row tracking, burst column sequencing,
// mode and extended mode registers, status crossed to the reference clock.
// Assumes command pins are launched by the controller on CK; RSTN is async.
`timescale 1ns/100ps
`include "dms_defines.svh"

module dms_top #(
  parameter bit X8 = 1'b1 // 1: x8 part, 14 row bits; 0: x16 part, 13 row bits
) (
  input wire logic REF_CLK, // System clock, 25 MHz
  input wire logic RSTN, // Async reset, active low
  input wire logic CK, // Link clock from the controller
  input wire logic CKE, // Clock enable
  input wire logic CS_N, // Chip select, active low
  input wire logic RAS_N, // Row strobe, active low
  input wire logic CAS_N, // Column strobe, active low
  input wire logic WE_N, // Write enable, active low
  input wire logic [2:0] BA, // Bank bits
  input wire logic [13:0] ADDR, // Address bits
  input wire logic ODT, // Termination control
  output logic BURST_VALID, // Beat present, link clock
  output logic BURST_WRITE, // Current burst is a write
  output logic [2:0] BURST_BANK, // Bank of burst
  output logic [13:0] BURST_ROW, // Row stored for the bank on BA the cycle before; the burst bank on the first beat
  output logic [9:0] BURST_COL, // Column of current beat
  output logic AUTO_PRE, // Burst ends with auto precharge
  output logic RSTROBE_OE, // Read-only strobe driven
  output logic WMASK_EN, // Write mask honoured
  output logic TERM_ON, // Termination applied
  output logic DLL_READY, // Loop enabled and settled
  output logic MODE_VALID, // Mode register written, reference clock
  output logic [13:0] MODE_WORD, // Mode register, reference clock
  output logic [13:0] EXT1_WORD // Extended register one, reference clock
);

  function automatic logic [9:0] burst_col(input logic [9:0] start, input logic [2:0] cnt,
                                           input logic bl8, input logic ilv);
    logic [9:0] col;
    col = start;
    if (bl8) begin
      col[2:0] = ilv ? (start[2:0] ^ cnt) : 3'(start[2:0] + cnt);
    end else begin
      col[1:0] = ilv ? (start[1:0] ^ cnt[1:0]) : 2'(start[1:0] + cnt[1:0]);
    end
    return col;
  endfunction : burst_col

  // Link-domain reset: async assert, release synchronised to CK
  logic lrst_s1_r;
  logic lrst_n;
  always_ff @(posedge CK or negedge RSTN) begin
    if (!RSTN) begin
      lrst_s1_r <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_s1_r <= 1'b1;
      lrst_n <= lrst_s1_r;
    end
  end

  dms_pkg::dms_cmd_s cmd;
  assign cmd = '{cke: CKE, cs_n: CS_N, ras_n: RAS_N, cas_n: CAS_N, we_n: WE_N, ba: BA, addr: ADDR};

  wire sel = cmd.cke && !cmd.cs_n;
  wire is_act = sel && !cmd.ras_n && cmd.cas_n && cmd.we_n;
  wire is_rd = sel && cmd.ras_n && !cmd.cas_n && cmd.we_n;
  wire is_wr = sel && cmd.ras_n && !cmd.cas_n && !cmd.we_n;
  wire is_pre = sel && !cmd.ras_n && cmd.cas_n && !cmd.we_n;
  wire is_mrs = sel && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
  wire mrs_mode = is_mrs && cmd.ba == `DMS_SEL_MODE;
  wire mrs_ext1 = is_mrs && cmd.ba == `DMS_SEL_EXT1;
  wire mrs_ext2 = is_mrs && cmd.ba == `DMS_SEL_EXT2;
  wire mrs_ext3 = is_mrs && cmd.ba == `DMS_SEL_EXT3;

  // x16 parts have no fourteenth row bit
  wire [13:0] row_in = X8 ? cmd.addr : {1'b0, cmd.addr[12:0]};

  logic [7:0] open_r;
  logic [7:0] open_nxt;
  logic [13:0] mode_r;
  logic [13:0] ext1_r;
  logic [13:0] ext2_r;
  logic [13:0] ext3_r;
  logic mode_valid_r;
  logic mode_tgl_r;

  wire bank_open = open_r[cmd.ba];
  wire rdwr_ok = (is_rd || is_wr) && bank_open;
  wire bl8 = mode_r[`DMS_MR_BL_MSB:`DMS_MR_BL_LSB] == `DMS_BL_CODE_8;
  wire ilv = mode_r[`DMS_MR_BT_BIT];
  wire [3:0] burst_len = bl8 ? 4'h8 : 4'h4;
  wire rstrobe_on = X8 && ext1_r[`DMS_E1_RSTROBE_BIT];

  // Burst sequencer
  dms_pkg::dms_burst_e bst_r;
  dms_pkg::dms_burst_e bst_nxt;
  logic [9:0] start_r;
  logic [3:0] cnt_r;
  logic ap_r;
  wire last_beat = cnt_r == burst_len;

  always_comb begin
    bst_nxt = bst_r;
    unique case (bst_r)
      dms_pkg::BST_IDLE: begin
        if (rdwr_ok) begin
          bst_nxt = is_wr ? dms_pkg::BST_WRITE : dms_pkg::BST_READ;
        end
      end
      dms_pkg::BST_READ, dms_pkg::BST_WRITE: begin
        // A new column command restarts the burst in place
        if (rdwr_ok) begin
          bst_nxt = is_wr ? dms_pkg::BST_WRITE : dms_pkg::BST_READ;
        end else if (last_beat) begin
          bst_nxt = dms_pkg::BST_IDLE;
        end
      end
      default: bst_nxt = dms_pkg::BST_IDLE;
    endcase
  end

  // Bank open bits
  always_comb begin
    open_nxt = open_r;
    if (bst_r != dms_pkg::BST_IDLE && last_beat && ap_r && !rdwr_ok) begin
      open_nxt[BURST_BANK] = 1'b0;
    end
    if (is_act) begin
      open_nxt[cmd.ba] = 1'b1;
    end else if (is_pre && cmd.addr[`DMS_ALLBANK_BIT]) begin
      open_nxt = 8'h00;
    end else if (is_pre) begin
      open_nxt[cmd.ba] = 1'b0;
    end
  end

  always_ff @(posedge CK or negedge lrst_n) begin
    if (!lrst_n) begin
      bst_r <= dms_pkg::BST_IDLE;
      open_r <= 8'h00;
    end else begin
      bst_r <= bst_nxt;
      open_r <= open_nxt;
    end
  end

  always_ff @(posedge CK or negedge lrst_n) begin
    if (!lrst_n) begin
      start_r <= 10'h000;
      cnt_r <= 4'h0;
      ap_r <= 1'b0;
      BURST_VALID <= 1'b0;
      BURST_WRITE <= 1'b0;
      BURST_BANK <= 3'h0;
      BURST_COL <= 10'h000;
      AUTO_PRE <= 1'b0;
    end else if (rdwr_ok) begin
      start_r <= cmd.addr[9:0];
      ap_r <= cmd.addr[`DMS_AP_BIT];
      cnt_r <= 4'h1;
      BURST_VALID <= 1'b1;
      BURST_WRITE <= is_wr;
      BURST_BANK <= cmd.ba;
      BURST_COL <= cmd.addr[9:0];
      AUTO_PRE <= cmd.addr[`DMS_AP_BIT];
    end else if (BURST_VALID && !last_beat) begin
      BURST_COL <= burst_col(start_r, cnt_r[2:0], bl8, ilv);
      cnt_r <= 4'(cnt_r + 4'h1);
    end else begin
      BURST_VALID <= 1'b0;
    end
  end

  dms_row_table #(
    .ROW_W(14),
    .DEPTH(8)
  ) u_rows (
    .clk(CK),
    .wr_en(is_act),
    .wr_idx(cmd.ba),
    .wr_row(row_in),
    .rd_idx(cmd.ba),
    .rd_row(BURST_ROW)
  );

  // Mode registers; none of this touches stored data
  always_ff @(posedge CK or negedge lrst_n) begin
    if (!lrst_n) begin
      mode_r <= `DMS_WORD_RESET;
      ext1_r <= `DMS_WORD_RESET;
      ext2_r <= `DMS_WORD_RESET;
      ext3_r <= `DMS_WORD_RESET;
      mode_valid_r <= 1'b0;
      mode_tgl_r <= 1'b0;
    end else begin
      if (mrs_mode) begin
        mode_r <= cmd.addr;
        mode_valid_r <= 1'b1;
      end
      if (mrs_ext1) begin
        ext1_r <= cmd.addr;
      end
      if (mrs_ext2) begin
        ext2_r <= cmd.addr;
      end
      if (mrs_ext3) begin
        ext3_r <= cmd.addr;
      end
      if (mrs_mode || mrs_ext1) begin
        mode_tgl_r <= ~mode_tgl_r;
      end
    end
  end

  // Loop settling: restarts on a loop reset, held off while the loop is disabled
  logic [7:0] lock_cnt_r;
  wire dll_rst = mrs_mode && cmd.addr[`DMS_MR_DLLRST_BIT];
  wire dll_off = ext1_r[`DMS_E1_DLLDIS_BIT];
  always_ff @(posedge CK or negedge lrst_n) begin
    if (!lrst_n) begin
      lock_cnt_r <= 8'h00;
      DLL_READY <= 1'b0;
    end else if (dll_rst || dll_off) begin
      lock_cnt_r <= 8'h00;
      DLL_READY <= 1'b0;
    end else if (lock_cnt_r != 8'(`DMS_DLL_LOCK_CLKS)) begin
      lock_cnt_r <= 8'(lock_cnt_r + 8'h01);
    end else begin
      DLL_READY <= 1'b1;
    end
  end

  // Strobe, mask and termination controls
  wire term_sel = ext1_r[`DMS_E1_RTT0_BIT] || ext1_r[`DMS_E1_RTT1_BIT];
  always_ff @(posedge CK or negedge lrst_n) begin
    if (!lrst_n) begin
      RSTROBE_OE <= 1'b0;
      WMASK_EN <= 1'b1;
      TERM_ON <= 1'b0;
    end else begin
      RSTROBE_OE <= rstrobe_on && (rdwr_ok ? is_rd : (BURST_VALID && !last_beat && !BURST_WRITE));
      WMASK_EN <= !rstrobe_on;
      TERM_ON <= ODT && term_sel && mode_valid_r;
    end
  end

  // Crossing to REF_CLK: words are held for at least a mode-set cycle after
  // the toggle, far longer than the four reference edges the capture needs.
  logic [2:0] tgl_sync_r;
  logic [2:0] vld_sync_r;
  logic tgl_seen_r;
  wire tgl_new = tgl_sync_r[1] == tgl_sync_r[2] && tgl_sync_r[2] != tgl_seen_r;
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tgl_sync_r <= 3'h0;
      vld_sync_r <= 3'h0;
      tgl_seen_r <= 1'b0;
      MODE_VALID <= 1'b0;
      MODE_WORD <= `DMS_WORD_RESET;
      EXT1_WORD <= `DMS_WORD_RESET;
    end else begin
      tgl_sync_r <= {tgl_sync_r[1:0], mode_tgl_r};
      vld_sync_r <= {vld_sync_r[1:0], mode_valid_r};
      if (vld_sync_r[1] == vld_sync_r[2]) begin
        MODE_VALID <= vld_sync_r[2];
      end
      if (tgl_new) begin
        tgl_seen_r <= tgl_sync_r[2];
        MODE_WORD <= mode_r;
        EXT1_WORD <= ext1_r;
      end
    end
  end

  chk_burst_len4 : assert property (@(posedge CK) disable iff (!lrst_n)
    $rose(BURST_VALID) && !bl8 |-> BURST_VALID [*4])
    else $error("Four-beat burst ended early");

  chk_burst_len8 : assert property (@(posedge CK) disable iff (!lrst_n)
    $rose(BURST_VALID) && bl8 |-> BURST_VALID [*8])
    else $error("Eight-beat burst ended early");

  chk_burst_start : assert property (@(posedge CK) disable iff (!lrst_n)
    rdwr_ok |=> BURST_VALID && BURST_COL == $past(cmd.addr[9:0]) && AUTO_PRE == $past(cmd.addr[10]))
    else $error("Burst did not start at commanded column");

  chk_act_opens : assert property (@(posedge CK) disable iff (!lrst_n)
    is_act |=> open_r[$past(cmd.ba)])
    else $error("Activate left its bank closed");

  chk_closed_refused : assert property (@(posedge CK) disable iff (!lrst_n)
    (is_rd || is_wr) && !bank_open && !BURST_VALID |=> !BURST_VALID)
    else $error("Column command to closed bank accepted");

  chk_pre_all : assert property (@(posedge CK) disable iff (!lrst_n)
    is_pre && cmd.addr[10] |=> open_r == 8'h00)
    else $error("Precharge-all left a bank open");

  chk_mode_write : assert property (@(posedge CK) disable iff (!lrst_n)
    mrs_mode |=> mode_r == $past(cmd.addr) && mode_valid_r)
    else $error("Mode register not stored");

  chk_mrs_keeps : assert property (@(posedge CK) disable iff (!lrst_n)
    is_mrs && bst_r == dms_pkg::BST_IDLE |=> open_r == $past(open_r))
    else $error("Mode-set disturbed open banks");

  chk_rstrobe_read : assert property (@(posedge CK) disable iff (!lrst_n)
    RSTROBE_OE |-> BURST_VALID && !BURST_WRITE && !WMASK_EN)
    else $error("Read-only strobe driven outside a read");

  chk_dll_settle : assert property (@(posedge CK) disable iff (!lrst_n)
    dll_rst |=> !DLL_READY [*8])
    else $error("Loop reported ready too soon after reset");

endmodule : dms_top

// ---- verification/dms_ctrl_model.sv ----
// Controller-side model: drives the DDR2 command pins on the falling link clock edge.
// Assumes the bench calls one of its tasks at a time; the link clock runs free.
`timescale 1ns/100ps
module dms_ctrl_model #(
  parameter int PWR_CK = 1600, // Stable-power wait, link clocks
  parameter int NOP_CK = 4 // Quiet time after clock enable rises
) (
  input wire logic ck, // Link clock
  output dms_pkg::dms_cmd_s cmd, // Command pins
  output logic odt // Termination control
);
  initial begin
    cmd = '{cs_n: 1'b1, default: '0};
    odt = 1'b0;
  end

  task automatic send(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a);
    @(negedge ck);
    {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} = c;
    cmd.ba = ba;
    cmd.addr = a;
    @(negedge ck);
    // Bank and address lines are inverted when deselected, so a late sample is caught
    cmd.cs_n = 1'b1;
    cmd.ba = ~ba;
    cmd.addr = ~a;
  endtask : send

  task automatic mode_set(input logic [2:0] ba, input logic [13:0] a);
    send(4'b0010, 3'h0, 14'h0400);
    send(4'b0000, ba, a);
  endtask : mode_set

  task automatic set_odt(input logic v);
    @(negedge ck);
    odt = v;
  endtask : set_odt

  task automatic init(input logic [13:0] mode, input logic [13:0] e1);
    repeat (PWR_CK) @(negedge ck);
    cmd.cke = 1'b1;
    repeat (NOP_CK) @(negedge ck);
    send(4'b0010, 3'h0, 14'h0400);
    send(4'b0000, 3'h2, 14'h0000);
    send(4'b0000, 3'h3, 14'h0000);
    send(4'b0000, 3'h1, e1 & 14'h1c7e);
    send(4'b0000, 3'h0, mode | 14'h0100);
    send(4'b0010, 3'h0, 14'h0400);
    send(4'b0001, 3'h0, 14'h0000);
    send(4'b0001, 3'h0, 14'h0000);
    send(4'b0000, 3'h0, mode & 14'h3eff);
    repeat (200) @(negedge ck);
    send(4'b0000, 3'h1, (e1 & 14'h1c7e) | 14'h0380);
    send(4'b0000, 3'h1, e1 & 14'h1c7e);
  endtask : init
endmodule : dms_ctrl_model

// ---- verification/test_ddr2_init_and_mode_setup.sv ----
// Self-checking bench for the DDR2 command decoder with a controller model.
// Assumes dms_top with X8 set; link clock 125 ns, reference clock 40 ns.
`timescale 1ns/100ps
module test_ddr2_init_and_mode_setup;
  typedef struct {
    logic wr;
    logic bl8;
    logic ilv;
    logic [2:0] bank;
    logic [13:0] row;
    logic [9:0] col;
    logic [0:7][9:0] cols;
  } dms_case_s;

  localparam logic [3:0] c_act = 4'b0011;
  localparam logic [3:0] c_rd = 4'b0101;
  localparam logic [3:0] c_wr = 4'b0100;
  localparam logic [3:0] c_pre = 4'b0010;

  logic ref_clk = 1'b0;
  logic ck = 1'b0;
  logic rstn = 1'b0;
  dms_pkg::dms_cmd_s cmd;
  logic odt;
  logic burst_valid, burst_write, auto_pre, rstrobe_oe, wmask_en, term_on, dll_ready, mode_valid;
  logic [2:0] burst_bank;
  logic [13:0] burst_row, mode_word, ext1_word;
  logic [9:0] burst_col;
  int n_errors = 0;
  int samples_checked = 0;
  // Start column, then the column expected at each beat
  dms_case_s cases [4] = '{
    '{1'b0, 1'b0, 1'b0, 3'h1, 14'h0005, 10'h006,
      '{10'h006, 10'h007, 10'h004, 10'h005, 10'h000, 10'h000, 10'h000, 10'h000}},
    '{1'b1, 1'b1, 1'b1, 3'h7, 14'h3fff, 10'h3fd,
      '{10'h3fd, 10'h3fc, 10'h3ff, 10'h3fe, 10'h3f9, 10'h3f8, 10'h3fb, 10'h3fa}},
    '{1'b0, 1'b1, 1'b0, 3'h0, 14'h1234, 10'h00e,
      '{10'h00e, 10'h00f, 10'h008, 10'h009, 10'h00a, 10'h00b, 10'h00c, 10'h00d}},
    '{1'b1, 1'b0, 1'b1, 3'h4, 14'h2000, 10'h201,
      '{10'h201, 10'h200, 10'h203, 10'h202, 10'h000, 10'h000, 10'h000, 10'h000}}
  };

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    #7;
    forever #62.5 ck = ~ck;
  end

  dms_ctrl_model u_ctrl (.ck(ck), .cmd(cmd), .odt(odt));

  dms_top #(.X8(1'b1)) DUT (
    .REF_CLK(ref_clk), .RSTN(rstn), .CK(ck), .CKE(cmd.cke), .CS_N(cmd.cs_n), .RAS_N(cmd.ras_n),
    .CAS_N(cmd.cas_n), .WE_N(cmd.we_n), .BA(cmd.ba), .ADDR(cmd.addr), .ODT(odt),
    .BURST_VALID(burst_valid), .BURST_WRITE(burst_write), .BURST_BANK(burst_bank), .BURST_ROW(burst_row),
    .BURST_COL(burst_col), .AUTO_PRE(auto_pre), .RSTROBE_OE(rstrobe_oe), .WMASK_EN(wmask_en),
    .TERM_ON(term_on), .DLL_READY(dll_ready), .MODE_VALID(mode_valid), .MODE_WORD(mode_word),
    .EXT1_WORD(ext1_word)
  );

  task automatic complete_run;
    $display("Checks made: %0d, mismatches: %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s is %h, wanted %h", $time, what, got, exp);
    end
  endtask : check

  task automatic beats(input int n, input logic v);
    // Checks the current cycle first: a burst is already up when send returns
    repeat (n) begin
      check(burst_valid, v, "beat present");
      @(negedge ck);
    end
  endtask : beats

  // The words cross clock domains, so allow a bounded number of reference edges
  task automatic sync_check(input logic [13:0] m, input logic [13:0] e);
    for (int t = 0; t < 12 && (mode_word !== m || ext1_word !== e); t++) @(negedge ref_clk);
    check({mode_valid, mode_word, ext1_word}, {1'b1, m, e}, "mode words");
  endtask : sync_check

  task automatic do_reset;
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (5) @(negedge ref_clk);
    repeat (3) @(posedge ck);
    @(negedge ref_clk);
    check({mode_valid, dll_ready, wmask_en, burst_valid, term_on, mode_word}, 19'h10000, "in reset");
    rstn = 1'b1;
    repeat (3) @(posedge ck);
    @(negedge ck);
    check({mode_valid, wmask_en, burst_valid}, 3'b010, "after reset");
  endtask : do_reset

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end

  initial begin
    do_reset();
    u_ctrl.init(14'h0052, 14'h0804);
    sync_check(14'h0052, 14'h0804);
    check({dll_ready, wmask_en}, 2'b10, "loop and mask");
    foreach (cases[i]) begin
      u_ctrl.mode_set(3'h0, {10'h005, cases[i].ilv, 2'b01, cases[i].bl8});
      u_ctrl.send(c_act, cases[i].bank, cases[i].row);
      u_ctrl.send(cases[i].wr ? c_wr : c_rd, cases[i].bank, {4'h0, cases[i].col});
      // The first beat is already on the outputs when the column command's send returns
      for (int k = 0; k < (cases[i].bl8 ? 8 : 4); k++) begin
        check(burst_valid, 1'b1, "beat present");
        check(burst_col, cases[i].cols[k], "beat column");
        check(burst_write, cases[i].wr, "direction");
        check(rstrobe_oe, !cases[i].wr, "read strobe");
        if (k == 0) begin
          check({burst_bank, burst_row, auto_pre}, {cases[i].bank, cases[i].row, 1'b0}, "bank row");
        end
        @(negedge ck);
      end
      beats(1, 1'b0);
      sync_check({10'h005, cases[i].ilv, 2'b01, cases[i].bl8}, 14'h0804);
    end
    // Auto precharge closes the bank, so a later read is dropped
    u_ctrl.mode_set(3'h0, 14'h0052);
    u_ctrl.send(c_act, 3'h2, 14'h0009);
    u_ctrl.send(c_rd, 3'h2, 14'h0404);
    check({burst_valid, auto_pre}, 2'b11, "auto precharge");
    @(negedge ck);
    beats(3, 1'b1);
    beats(2, 1'b0);
    u_ctrl.send(c_rd, 3'h2, 14'h0004);
    beats(5, 1'b0);
    u_ctrl.send(c_act, 3'h3, 14'h0001);
    u_ctrl.send(c_act, 3'h5, 14'h0002);
    u_ctrl.send(c_pre, 3'h3, 14'h0000);
    u_ctrl.send(c_rd, 3'h5, 14'h0000);
    beats(4, 1'b1);
    beats(1, 1'b0);
    u_ctrl.send(c_rd, 3'h3, 14'h0000);
    beats(5, 1'b0);
    u_ctrl.send(c_pre, 3'h0, 14'h0400);
    u_ctrl.send(c_rd, 3'h5, 14'h0000);
    beats(5, 1'b0);
    // Strobe off and termination off, then termination on
    u_ctrl.mode_set(3'h1, 14'h0000);
    sync_check(14'h0052, 14'h0000);
    check(wmask_en, 1'b1, "mask on");
    u_ctrl.set_odt(1'b1);
    repeat (2) @(negedge ck);
    check(term_on, 1'b0, "termination disabled");
    u_ctrl.mode_set(3'h1, 14'h0004);
    repeat (2) @(negedge ck);
    check(term_on, 1'b1, "termination on");
    u_ctrl.set_odt(1'b0);
    repeat (2) @(negedge ck);
    check(term_on, 1'b0, "termination off");
    // A loop reset needs 200 link clocks before the loop is ready
    u_ctrl.mode_set(3'h0, 14'h0152);
    repeat (190) @(negedge ck);
    check(dll_ready, 1'b0, "loop settling");
    repeat (20) @(negedge ck);
    check(dll_ready, 1'b1, "loop ready");
    do_reset();
    complete_run();
  end
endmodule : test_ddr2_init_and_mode_setup
